// file: testbench/fnuer_iu_model.sv
// Purpose: integer unit model that issues fp ops and takes outcomes
// Assumes: outcome arrives within a few cycles of the op pulse
// Notes: operands inverted after each op so stale values never match
`timescale 1ns/100ps
module fnuer_iu_model import fnuer_pkg::*; (
	// clock
	input  wire logic        mclk,
	// to block
	output logic             opValid,
	output fnuer_op_t        opKind,
	output logic             srcDbl,
	output logic             dstDbl,
	output logic      [63:0] opA,
	output logic      [63:0] opB,
	output logic      [63:0] arResult,
	output logic      [31:0] intResult,
	output logic      [1:0]  cmpFcc,
	output logic             arInvalid,
	output logic             arOverflow,
	output logic             arDivZero,
	output logic             arInexact,
	output logic             arTiny,
	output logic             arSubRes,
	// from block
	input  wire logic        resValid,
	input  wire logic        resWe,
	input  wire logic [63:0] result,
	input  wire logic        fccWe,
	input  wire logic [1:0]  fcc,
	input  wire logic        trapTake,
	input  wire logic [4:0]  trapCause
);
	initial begin
		{opValid, srcDbl, dstDbl, arInvalid, arOverflow, arDivZero, arInexact, arTiny, arSubRes} = '0;
		opKind = OP_ARITH1;
		{opA, opB} = '0;
		arResult = 64'h123;
		intResult = 32'h55;
		cmpFcc = 2'h1;
	end

	task automatic issue(input fnuer_op_t k, input logic dd, input logic [63:0] a, input logic [63:0] b,
		input logic [3:0] fl, output logic [66:0] got, output bit ok);
		ok = 0;
		got = '0;
		@(posedge mclk);
		opValid <= 1'b1;
		opKind <= k;
		srcDbl <= 1'b0;
		dstDbl <= dd;
		opA <= a;
		opB <= b;
		{arInvalid, arTiny, arInexact, arSubRes} <= fl;
		@(posedge mclk);
		opValid <= 1'b0;
		opA <= ~a;
		opB <= ~b;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge mclk);
			if (resValid === 1'b1) begin
				ok = 1;
				got = {resWe, fccWe, trapTake, resWe ? result : fccWe ? {62'h0, fcc} : {59'h0, trapCause}};
			end
		end
	endtask : issue
endmodule : fnuer_iu_model

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the fp NaN and underflow rules
// Assumes: default instance without nonstandard support; a second instance with it checks flushing
// Notes: outcome word is {resWe, fccWe, trapTake, value}
`timescale 1ns/100ps
module tb_top import fnuer_pkg::*; ;
	logic        mclk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, intResult;
	logic        opValid, srcDbl, dstDbl, arInvalid, arOverflow, arDivZero, arInexact, arTiny, arSubRes;
	logic        resValid, resWe, fccWe, trapTake, nsActive, nsFlag;
	fnuer_op_t   opKind;
	logic [63:0] opA, opB, arResult, result, nsResult;
	logic [1:0]  cmpFcc, fcc;
	logic [4:0]  trapCause;
	int          miscompares, checksDone;
	localparam logic [2:0]  R = 3'b100, F = 3'b010, T = 3'b001;
	localparam logic [63:0] SN = 64'h7F800001, SN2 = 64'h7F800003, QN = 64'h7FC00002, QN1 = 64'h7FC00005;
	localparam logic [63:0] ONE = 64'h3F800000, AR = 64'h123;

	fnuer_top u_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.opValid, .opKind, .srcDbl, .dstDbl, .opA, .opB, .arResult, .intResult, .cmpFcc, .arInvalid, .arOverflow,
		.arDivZero, .arInexact, .arTiny, .arSubRes, .resValid, .resWe, .result, .fccWe, .fcc, .trapTake,
		.trapCause, .nsActive);
	fnuer_top #(.NS_IMPL(1'b1)) u_ns (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(),
		.pready(), .pslverr(), .opValid, .opKind, .srcDbl, .dstDbl, .opA, .opB, .arResult, .intResult, .cmpFcc,
		.arInvalid, .arOverflow, .arDivZero, .arInexact, .arTiny, .arSubRes, .resValid(), .resWe(),
		.result(nsResult), .fccWe(), .fcc(), .trapTake(), .trapCause(), .nsActive(nsFlag));
	fnuer_iu_model u_iu (.mclk, .opValid, .opKind, .srcDbl, .dstDbl, .opA, .opB, .arResult, .intResult,
		.cmpFcc, .arInvalid, .arOverflow, .arDivZero, .arInexact, .arTiny, .arSubRes, .resValid, .resWe,
		.result, .fccWe, .fcc, .trapTake, .trapCause);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic test_done;
		$display("checks %0d miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic cmp(input logic [66:0] g, input logic [66:0] e);
		checksDone++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
		bit done;
		done = 0;
		r = '0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (int i = 0; i < 8 && !done; i++) begin
			@(posedge mclk);
			if (pready === 1'b1) begin
				done = 1;
				r = {pslverr, prdata};
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!done) begin
			miscompares++;
			test_done;
		end
	endtask : apb

	// status cleared first; trapped ops must leave codes and accrued bits alone
	task automatic chk(input fnuer_op_t k, input logic dd, input logic [63:0] a, input logic [63:0] b,
		input logic [3:0] fl, input logic [66:0] e, input logic [4:0] cx);
		logic [66:0] g;
		logic [32:0] r;
		bit          ok;
		apb(1'b1, 8'h04, 32'h0, r);
		u_iu.issue(k, dd, a, b, fl, g, ok);
		if (!ok) begin
			miscompares++;
			test_done;
		end
		cmp(g, e);
		apb(1'b0, 8'h04, 32'h0, r);
		cmp({34'h0, r}, {55'h0, e[65] ? e[1:0] : 2'h0, e[64] ? 5'h00 : cx, cx});
	endtask : chk

	initial begin
		logic [32:0] r;
		{srst, psel, penable, pwrite} = 4'hF ^ 4'h7;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		checksDone = 0;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		apb(1'b0, 8'h08, 32'h0, r);
		cmp({34'h0, r}, {34'h0, 1'b1, 32'h0});
		apb(1'b1, 8'h00, 32'h3F, r);
		apb(1'b0, 8'h00, 32'h0, r);
		cmp({34'h0, r}, 67'h1F);
		cmp({66'h0, nsActive}, 67'h0);
		apb(1'b1, 8'h00, 32'h00, r);
		chk(OP_ARITH2, 1'b0, QN1, QN, 4'h0, {R, QN}, 5'h00);
		chk(OP_ARITH2, 1'b0, SN, SN2, 4'h0, {R, 64'h7FC00003}, 5'h10);
		chk(OP_ARITH2, 1'b0, SN, ONE, 4'h0, {R, 64'h7FC00001}, 5'h10);
		chk(OP_ARITH2, 1'b0, ONE, QN, 4'h0, {R, QN}, 5'h00);
		chk(OP_ARITH1, 1'b0, QN, ONE, 4'h0, {R, QN}, 5'h00);
		chk(OP_ARITH1, 1'b0, SN, ONE, 4'h0, {R, 64'h7FC00001}, 5'h10);
		chk(OP_ARITH1, 1'b0, ONE, ONE, 4'h8, {R, 64'h7FFFFFFF}, 5'h10);
		chk(OP_CVT, 1'b1, SN, ONE, 4'h0, {R, 64'h7FF8000020000000}, 5'h10);
		chk(OP_CMP, 1'b0, QN, ONE, 4'h0, {F, 64'h3}, 5'h00);
		chk(OP_CMP, 1'b0, ONE, SN, 4'h0, {F, 64'h3}, 5'h10);
		chk(OP_CMPE, 1'b0, QN, ONE, 4'h0, {F, 64'h3}, 5'h10);
		chk(OP_CMP, 1'b0, ONE, ONE, 4'h0, {F, 64'h1}, 5'h00);
		chk(OP_FTOI, 1'b0, 64'h7F800000, ONE, 4'h0, {R, 64'h7FFFFFFF}, 5'h10);
		chk(OP_FTOI, 1'b0, 64'hCF000001, ONE, 4'h0, {R, 64'h80000000}, 5'h10);
		chk(OP_FTOI, 1'b0, 64'h4F000000, ONE, 4'h0, {R, 64'h7FFFFFFF}, 5'h10);
		chk(OP_FTOI, 1'b0, 64'hCF000000, ONE, 4'h0, {R, 64'h55}, 5'h00);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h7, {R, AR}, 5'h05);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h5, {R, AR}, 5'h00);
		apb(1'b1, 8'h00, 32'h04, r);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h5, {T, 64'h04}, 5'h04);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h4, {R, AR}, 5'h00);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h6, {T, 64'h04}, 5'h04);
		apb(1'b1, 8'h00, 32'h01, r);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h7, {T, 64'h01}, 5'h01);
		apb(1'b1, 8'h00, 32'h10, r);
		chk(OP_ARITH1, 1'b0, SN, ONE, 4'h0, {T, 64'h10}, 5'h10);
		chk(OP_ARITH2, 1'b0, SN, ONE, 4'h0, {T, 64'h10}, 5'h10);
		apb(1'b1, 8'h00, 32'h20, r);
		chk(OP_ARITH2, 1'b0, ONE, ONE, 4'h7, {R, AR}, 5'h05);
		cmp({3'h0, nsResult}, 67'h0);
		cmp({66'h0, nsFlag}, 67'h1);
		test_done;
	end
endmodule : tb_top

// file: verilog/fnuer_exc_eval.sv
// Purpose: exception vector, trap decision and trap cause
// Assumes: tiny is judged on the unrounded value, overflow after rounding
// Notes: trap priority nv, of, uf, dz, nx
`timescale 1ns/100ps
module fnuer_exc_eval import fnuer_pkg::*; (
	// causes
	input  wire logic       nanHit,
	input  wire logic       nanInvalid,
	input  wire logic       arInvalid,
	input  wire logic       arOverflow,
	input  wire logic       arDivZero,
	input  wire logic       arInexact,
	input  wire logic       arTiny,
	input  wire logic       arSubRes,
	input  wire logic       ftoiInv,
	input  wire logic       nsOn,
	input  wire logic       opSub,
	input  wire logic [4:0] trapEn,
	// outcome
	output logic [4:0]      excVec,
	output logic            trapHit,
	output logic [4:0]      trapCause,
	output logic            flushRes
);
	logic [4:0] tr;

	always_comb begin
		excVec = 5'h00;
		if (nanHit) begin
			excVec[EXC_NV] = nanInvalid;
		end else begin
			excVec[EXC_NV] = arInvalid | ftoiInv;
			excVec[EXC_OF] = arOverflow;
			excVec[EXC_DZ] = arDivZero;
			if (trapEn[EXC_UF])
				excVec[EXC_UF] = arTiny & (arInexact | arSubRes);
			else
				excVec[EXC_UF] = arTiny & arInexact;
			excVec[EXC_NX] = arInexact;
			if (nsOn && arSubRes) begin
				excVec[EXC_UF] = 1'h1;
				excVec[EXC_NX] = 1'h1;
			end
			if (opSub && excVec == 5'h00)
				excVec[EXC_NX] = 1'h1;
		end
		tr = excVec & trapEn;
		trapHit = |tr;
		trapCause = 5'h00;
		for (int i = EXC_NV; i >= EXC_NX; i--) begin
			if (tr[i] && trapCause == 5'h00)
				trapCause[i] = 1'h1;
		end
		flushRes = nsOn & arSubRes & !trapHit;
	end
endmodule : fnuer_exc_eval

// file: verilog/fnuer_nan_sel.sv
// Purpose: NaN detection and NaN result choice for one operation
// Assumes: operands are in the source format
// Notes: purely combinational
`timescale 1ns/100ps
module fnuer_nan_sel import fnuer_pkg::*; (
	// operation
	input  wire fnuer_op_t   opKind,
	input  wire logic        srcDbl,
	input  wire logic        dstDbl,
	input  wire logic [63:0] opA,
	input  wire logic [63:0] opB,
	// outcome
	output logic             nanHit,
	output logic             nanInvalid,
	output logic [63:0]      nanRes
);
	logic aN, aS, bN, bS;

	always_comb begin
		aN = isNan(opA, srcDbl);
		aS = isSnan(opA, srcDbl);
		bN = isNan(opB, srcDbl);
		bS = isSnan(opB, srcDbl);
		nanHit = 1'h0;
		nanInvalid = 1'h0;
		nanRes = opA;
		case (opKind)
			OP_ARITH1: begin
				nanHit = aN;
				nanInvalid = aS;
				nanRes = aS ? quietNan(opA, srcDbl) : opA;
			end
			OP_ARITH2: begin
				nanHit = aN | bN;
				nanInvalid = aS | bS;
				if (bS)
					nanRes = quietNan(opB, srcDbl);
				else if (aS)
					nanRes = quietNan(opA, srcDbl);
				else if (bN)
					nanRes = opB;
				else
					nanRes = opA;
			end
			OP_CVT: begin
				nanHit = aN;
				nanInvalid = aS;
				nanRes = nanTransform(opA, srcDbl, dstDbl);
			end
			OP_CMP: begin
				nanHit = aN | bN;
				nanInvalid = aS | bS;
			end
			OP_CMPE: begin
				nanHit = aN | bN;
				nanInvalid = aN | bN;
			end
			default: begin
				nanHit = 1'h0;
			end
		endcase
	end
endmodule : fnuer_nan_sel

// file: verilog/fnuer_pkg.sv
// Purpose: constants, op codes and NaN helpers for the fp exception block
// Assumes: single format sits in bits 31:0 of a 64-bit operand
// Notes: exception vectors are {nv, of, uf, dz, nx}
// Operation
// - precision convert of signaling NaN: invalid, result is transformed quiet NaN
// - exception compare with any NaN: invalid, condition codes unordered
// - ordinary compare with a signaling NaN: invalid, condition codes unordered
// - ordinary compare with quiet NaN only: no exception, codes unordered
// - invalid without NaN operands returns positive quiet NaN of all ones
// - one-operand op on quiet NaN: no exception, operand returned unchanged
// - one-operand op on signaling NaN: invalid, operand with quiet bit set
// - two operands both quiet NaN: no exception, second operand returned
// - two operands both signaling: invalid, second operand with quiet bit set
// - exactly one signaling NaN: invalid, that NaN quieted is returned
// - no signaling, one quiet NaN: no exception, that NaN returned
// - underflow trap enabled: tiny before rounding means underflow
// - underflow trap disabled: underflow needs tiny and inexact
// - exact tiny result traps only if enabled and result subnormal
// - inexact tiny: underflow trap, else inexact trap, else both flags
// - overflow is judged after rounding, underflow before
// - float to integer invalid for NaN, infinity or out of range
// - untrapped bad integer conversion saturates by operand sign
// - without nonstandard support the nonstandard bit reads zero
// - nonstandard: subnormal operands become zero, inexact if nothing else; code checks opB only for OP_ARITH2, not for compares
// - nonstandard: untrapped subnormal results flush to zero, underflow and inexact
// - NaN transform copies high fraction bits and forces quiet bit
// - trap leaves result, codes and accrued flags; one current bit set
package fnuer_pkg;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STAT   = 8'h04;
	localparam int          EXC_NX      = 0;
	localparam int          EXC_DZ      = 1;
	localparam int          EXC_UF      = 2;
	localparam int          EXC_OF      = 3;
	localparam int          EXC_NV      = 4;
	localparam int          CTRL_NS_BIT = 5;
	localparam logic [5:0]  CTRL_RESET  = 6'h00;
	localparam logic [4:0]  EXC_RESET   = 5'h00;
	localparam logic [1:0]  FCC_RESET   = 2'h0;
	localparam logic [1:0]  FCC_UNORD   = 2'h3;
	localparam logic [63:0] DNAN_D      = 64'h7FFFFFFFFFFFFFFF;
	localparam logic [63:0] DNAN_S      = 64'h000000007FFFFFFF;
	localparam logic [63:0] QBIT_D      = 64'h0008000000000000;
	localparam logic [31:0] QBIT_S      = 32'h00400000;
	localparam logic [31:0] INT_POS_SAT = 32'h7FFFFFFF;
	localparam logic [31:0] INT_NEG_SAT = 32'h80000000;
	localparam logic [10:0] FTOI_EXP_D  = 11'h41E;
	localparam logic [7:0]  FTOI_EXP_S  = 8'h9E;

	typedef enum logic [2:0] {
		OP_ARITH1 = 3'b000,
		OP_ARITH2 = 3'b001,
		OP_CVT    = 3'b010,
		OP_FTOI   = 3'b011,
		OP_CMP    = 3'b100,
		OP_CMPE   = 3'b101
	} fnuer_op_t;

	function automatic logic expOnes(input logic [63:0] x, input logic dbl);
		return dbl ? &x[62:52] : &x[30:23];
	endfunction : expOnes

	function automatic logic fracZero(input logic [63:0] x, input logic dbl);
		return dbl ? ~|x[51:0] : ~|x[22:0];
	endfunction : fracZero

	function automatic logic isNan(input logic [63:0] x, input logic dbl);
		return expOnes(x, dbl) && !fracZero(x, dbl);
	endfunction : isNan

	function automatic logic isSnan(input logic [63:0] x, input logic dbl);
		return isNan(x, dbl) && !(dbl ? x[51] : x[22]);
	endfunction : isSnan

	function automatic logic isSub(input logic [63:0] x, input logic dbl);
		return (dbl ? ~|x[62:52] : ~|x[30:23]) && !fracZero(x, dbl);
	endfunction : isSub

	function automatic logic [63:0] quietNan(input logic [63:0] x, input logic dbl);
		return dbl ? (x | QBIT_D) : {32'h0, x[31:0] | QBIT_S};
	endfunction : quietNan

	function automatic logic [63:0] nanTransform(input logic [63:0] x, input logic sd, input logic dd);
		if (sd == dd)
			return quietNan(x, sd);
		if (dd)
			return {x[31], 11'h7FF, x[22:0], 29'h0} | QBIT_D;
		return {32'h0, x[63], 8'hFF, x[51:29] | QBIT_S[22:0]};
	endfunction : nanTransform

	function automatic logic ftoiBad(input logic [63:0] x, input logic dbl);
		if (dbl)
			return (x[62:52] > FTOI_EXP_D) || (x[62:52] == FTOI_EXP_D && (!x[63] || |x[51:21]));
		return (x[30:23] > FTOI_EXP_S) || (x[30:23] == FTOI_EXP_S && (!x[31] || |x[22:0]));
	endfunction : ftoiBad
endpackage : fnuer_pkg

// file: verilog/fnuer_top.sv
// Purpose: NaN, underflow and conversion exception rules of the fpu
// Assumes: arithmetic datapath supplies rounded result and tiny/inexact flags
// Notes: outcome of an op appears one cycle after opValid
`timescale 1ns/100ps
module fnuer_top import fnuer_pkg::*; #(
	parameter bit NS_IMPL = 1'b0
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,

	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,

	// operation from integer unit
	input  wire logic        opValid,
	input  wire fnuer_op_t   opKind,
	input  wire logic        srcDbl,
	input  wire logic        dstDbl,
	input  wire logic [63:0] opA,
	input  wire logic [63:0] opB,

	// datapath results
	input  wire logic [63:0] arResult,
	input  wire logic [31:0] intResult,
	input  wire logic [1:0]  cmpFcc,
	input  wire logic        arInvalid,
	input  wire logic        arOverflow,
	input  wire logic        arDivZero,
	input  wire logic        arInexact,
	input  wire logic        arTiny,
	input  wire logic        arSubRes,

	// completion
	output logic             resValid,
	output logic             resWe,
	output logic      [63:0] result,
	output logic             fccWe,
	output logic      [1:0]  fcc,
	output logic             trapTake,
	output logic      [4:0]  trapCause,
	output logic             nsActive
);

	typedef struct packed {
		logic [5:0]  ctrl;
		logic [4:0]  cexc;
		logic [4:0]  aexc;
		logic [1:0]  fcc;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        resValid;
		logic        resWe;
		logic        fccWe;
		logic        trapTake;
		logic [4:0]  trapCause;
		logic [63:0] result;
	} fnuer_top_state_t;

	fnuer_top_state_t st_r;
	fnuer_top_state_t st_nxt;

	logic        nanHit;
	logic        nanInvalid;
	logic [63:0] nanRes;
	logic [4:0]  excVec;
	logic        trapHit;
	logic [4:0]  excCause;
	logic        flushRes;
	logic        nsOn;
	logic        opSub;
	logic        ftoiInv;
	logic        opSign;
	logic        isCmp;
	logic        apbAcc;
	logic        apbWr;
	logic [63:0] resPick;

	assign nsOn    = st_r.ctrl[CTRL_NS_BIT];
	assign isCmp   = (opKind == OP_CMP) || (opKind == OP_CMPE);
	assign opSign  = srcDbl ? opA[63] : opA[31];
	assign ftoiInv = (opKind == OP_FTOI) && ftoiBad(opA, srcDbl);
	assign apbAcc  = psel & penable & !st_r.pready;
	assign apbWr   = psel & penable & st_r.pready & pwrite & !st_r.pslverr;

	// subnormal opA, or opB of OP_ARITH2, counts as zero in nonstandard mode
	assign opSub = nsOn && (isSub(opA, srcDbl) || (opKind == OP_ARITH2 && isSub(opB, srcDbl)));

	fnuer_nan_sel u_nan (
		.opKind     (opKind),
		.srcDbl     (srcDbl),
		.dstDbl     (dstDbl),
		.opA        (opA),
		.opB        (opB),
		.nanHit     (nanHit),
		.nanInvalid (nanInvalid),
		.nanRes     (nanRes)
	);

	fnuer_exc_eval u_exc (
		.nanHit     (nanHit),
		.nanInvalid (nanInvalid),
		.arInvalid  (arInvalid),
		.arOverflow (arOverflow),
		.arDivZero  (arDivZero),
		.arInexact  (arInexact),
		.arTiny     (arTiny),
		.arSubRes   (arSubRes),
		.ftoiInv    (ftoiInv),
		.nsOn       (nsOn),
		.opSub      (opSub),
		.trapEn     (st_r.ctrl[4:0]),
		.excVec     (excVec),
		.trapHit    (trapHit),
		.trapCause  (excCause),
		.flushRes   (flushRes)
	);

	// result choice: NaN rules first, then saturation and flushing
	always_comb begin
		resPick = arResult;
		if (nanHit) begin
			resPick = nanRes;
		end else if (opKind == OP_FTOI) begin
			if (ftoiInv)
				resPick = {32'h0, opSign ? INT_NEG_SAT : INT_POS_SAT};
			else
				resPick = {32'h0, intResult};
		end else if (arInvalid) begin
			resPick = dstDbl ? DNAN_D : DNAN_S;
		end else if (flushRes) begin
			resPick = dstDbl ? {arResult[63], 63'h0} : {32'h0, arResult[31], 31'h0};
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.resValid = 1'h0;
		st_nxt.resWe = 1'h0;
		st_nxt.fccWe = 1'h0;
		st_nxt.trapTake = 1'h0;
		st_nxt.trapCause = 5'h00;

		// one wait state, then pready
		st_nxt.pready = apbAcc;
		st_nxt.pslverr = 1'h0;
		if (apbAcc) begin
			st_nxt.prdata = 32'h0;
			case (paddr)
				ADDR_CTRL: st_nxt.prdata = {26'h0, st_r.ctrl};
				ADDR_STAT: st_nxt.prdata = {20'h0, st_r.fcc, st_r.aexc, st_r.cexc};
				default: st_nxt.pslverr = 1'h1;
			endcase
		end
		if (apbWr) begin
			case (paddr)
				ADDR_CTRL: begin
					st_nxt.ctrl = {pwdata[CTRL_NS_BIT] & NS_IMPL, pwdata[4:0]};
				end
				ADDR_STAT: begin
					st_nxt.cexc = pwdata[4:0];
					st_nxt.aexc = pwdata[9:5];
					st_nxt.fcc = pwdata[11:10];
				end
				default: begin
					st_nxt.pslverr = 1'h0;
				end
			endcase
		end

		// hardware cexc and fcc updates win over a same-cycle software write; aexc gets excVec ORed into the written value
		if (opValid) begin
			st_nxt.resValid = 1'h1;
			if (trapHit) begin
				st_nxt.trapTake = 1'h1;
				st_nxt.trapCause = excCause;
				st_nxt.cexc = excCause;
			end else begin
				st_nxt.cexc = excVec;
				st_nxt.aexc = st_nxt.aexc | excVec;
				if (isCmp) begin
					st_nxt.fccWe = 1'h1;
					st_nxt.fcc = nanHit ? FCC_UNORD : cmpFcc;
				end else begin
					st_nxt.resWe = 1'h1;
					st_nxt.result = resPick;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RESET;
			st_r.cexc <= EXC_RESET;
			st_r.aexc <= EXC_RESET;
			st_r.fcc <= FCC_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata    = st_r.prdata;
	assign pready    = st_r.pready;
	assign pslverr   = st_r.pslverr;
	assign resValid  = st_r.resValid;
	assign resWe     = st_r.resWe;
	assign result    = st_r.result;
	assign fccWe     = st_r.fccWe;
	assign fcc       = st_r.fcc;
	assign trapTake  = st_r.trapTake;
	assign trapCause = st_r.trapCause;
	assign nsActive  = st_r.ctrl[CTRL_NS_BIT];

	property p_done;
		@(posedge mclk) disable iff (srst)
		opValid |=> resValid && (trapTake || resWe || fccWe);
	endproperty
	a_done: assert property (p_done) else $error("op did not complete next cycle");

	property p_trap_quiet;
		@(posedge mclk) disable iff (srst)
		trapTake |-> !resWe && !fccWe && $onehot(trapCause) && st_r.cexc == trapCause;
	endproperty
	a_trap_quiet: assert property (p_trap_quiet) else $error("trap wrote state or bad cause");

	property p_trap_aexc;
		@(posedge mclk) disable iff (srst)
		opValid && trapHit && !apbWr |=> st_r.aexc == $past(st_r.aexc) && st_r.fcc == $past(st_r.fcc);
	endproperty
	a_trap_aexc: assert property (p_trap_aexc) else $error("trap changed accrued flags");

	property p_cvt_snan;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_CVT && isSnan(opA, srcDbl) && !st_r.ctrl[EXC_NV]
		|=> resWe && result == $past(nanRes) && st_r.cexc[EXC_NV];
	endproperty
	a_cvt_snan: assert property (p_cvt_snan) else $error("convert of signaling NaN wrong");

	property p_cmpe;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_CMPE && nanHit && !st_r.ctrl[EXC_NV]
		|=> fccWe && fcc == FCC_UNORD && st_r.cexc[EXC_NV];
	endproperty
	a_cmpe: assert property (p_cmpe) else $error("exception compare with NaN wrong");

	property p_cmp_snan;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_CMP && (isSnan(opA, srcDbl) || isSnan(opB, srcDbl)) && !st_r.ctrl[EXC_NV]
		|=> fcc == FCC_UNORD && st_r.cexc[EXC_NV];
	endproperty
	a_cmp_snan: assert property (p_cmp_snan) else $error("compare with signaling NaN wrong");

	property p_cmp_qnan;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_CMP && nanHit && !isSnan(opA, srcDbl) && !isSnan(opB, srcDbl)
		|=> fccWe && !trapTake && fcc == FCC_UNORD && st_r.cexc == 5'h00;
	endproperty
	a_cmp_qnan: assert property (p_cmp_qnan) else $error("compare with quiet NaN wrong");

	property p_dnan;
		@(posedge mclk) disable iff (srst)
		opValid && (opKind == OP_ARITH1 || opKind == OP_ARITH2) && !nanHit && arInvalid && !st_r.ctrl[EXC_NV]
		|=> resWe && result == ($past(dstDbl) ? DNAN_D : DNAN_S);
	endproperty
	a_dnan: assert property (p_dnan) else $error("default NaN wrong");

	property p_q1;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_ARITH1 && isNan(opA, srcDbl) && !isSnan(opA, srcDbl)
		|=> result == $past(opA) && !trapTake && st_r.cexc == 5'h00;
	endproperty
	a_q1: assert property (p_q1) else $error("single quiet NaN not passed");

	property p_s1;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_ARITH1 && isSnan(opA, srcDbl) && !st_r.ctrl[EXC_NV]
		|=> result == ($past(srcDbl) ? ($past(opA) | QBIT_D) : {32'h0, QBIT_S | 32'($past(opA))})
		&& st_r.cexc[EXC_NV];
	endproperty
	a_s1: assert property (p_s1) else $error("single signaling NaN not quieted");

	property p_qq;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_ARITH2 && isNan(opA, srcDbl) && isNan(opB, srcDbl)
		&& !isSnan(opA, srcDbl) && !isSnan(opB, srcDbl)
		|=> result == $past(opB) && !trapTake;
	endproperty
	a_qq: assert property (p_qq) else $error("two quiet NaNs wrong pick");

	property p_ss;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_ARITH2 && isSnan(opA, srcDbl) && isSnan(opB, srcDbl) && !st_r.ctrl[EXC_NV]
		|=> result == ($past(srcDbl) ? ($past(opB) | QBIT_D) : {32'h0, QBIT_S | 32'($past(opB))})
		&& st_r.cexc[EXC_NV];
	endproperty
	a_ss: assert property (p_ss) else $error("two signaling NaNs wrong pick");

	property p_s_one;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_ARITH2 && isSnan(opA, srcDbl) && !isSnan(opB, srcDbl) && st_r.ctrl[EXC_NV]
		|=> trapTake && trapCause[EXC_NV] && !resWe;
	endproperty
	a_s_one: assert property (p_s_one) else $error("one signaling NaN did not trap");

	property p_q_one;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_ARITH2 && !isNan(opA, srcDbl) && isNan(opB, srcDbl) && !isSnan(opB, srcDbl)
		|=> result == $past(opB) && st_r.cexc == 5'h00;
	endproperty
	a_q_one: assert property (p_q_one) else $error("one quiet NaN wrong pick");

	property p_uf_exact;
		@(posedge mclk) disable iff (srst)
		opValid && !nanHit && !isCmp && opKind != OP_FTOI && arTiny && !arInexact && arSubRes
		&& st_r.ctrl[4:0] == 5'h04 && !arInvalid && !arOverflow && !arDivZero
		|=> trapTake && trapCause == 5'h04;
	endproperty
	a_uf_exact: assert property (p_uf_exact) else $error("exact subnormal missed trap");

	property p_uf_off;
		@(posedge mclk) disable iff (srst)
		opValid && !nanHit && arTiny && !arInexact && !st_r.ctrl[EXC_UF] && !nsOn
		|=> !st_r.cexc[EXC_UF];
	endproperty
	a_uf_off: assert property (p_uf_off) else $error("exact tiny flagged underflow");

	property p_tiny_nx;
		@(posedge mclk) disable iff (srst)
		opValid && !nanHit && arTiny && arInexact && st_r.ctrl[4:0] == 5'h01
		&& !arInvalid && !arOverflow && !arDivZero && !ftoiInv
		|=> trapTake && trapCause == 5'h01 && st_r.aexc == $past(st_r.aexc);
	endproperty
	a_tiny_nx: assert property (p_tiny_nx) else $error("inexact tiny did not take inexact trap");

	property p_ftoi;
		@(posedge mclk) disable iff (srst)
		opValid && opKind == OP_FTOI && ftoiInv && !st_r.ctrl[EXC_NV]
		|=> result[31:0] == ($past(opSign) ? INT_NEG_SAT : INT_POS_SAT) && st_r.cexc[EXC_NV];
	endproperty
	a_ftoi: assert property (p_ftoi) else $error("integer saturation wrong");

	property p_ns_ro;
		@(posedge mclk) disable iff (srst)
		!NS_IMPL |-> !nsActive;
	endproperty
	a_ns_ro: assert property (p_ns_ro) else $error("nonstandard bit set without support");

	property p_ns_flush;
		@(posedge mclk) disable iff (srst)
		opValid && nsOn && arSubRes && !nanHit && !arInvalid && opKind == OP_ARITH2 && st_r.ctrl[4:0] == 5'h00
		|=> resWe && result[30:0] == 31'h0 && st_r.cexc[EXC_UF] && st_r.cexc[EXC_NX];
	endproperty
	a_ns_flush: assert property (p_ns_flush) else $error("nonstandard flush wrong");

endmodule : fnuer_top
